// ===== rtl/timer2.sv
// Local design decision: the Wishbone interface to the registers.
`default_nettype none
`include "timer2_regs.svh"
module timer2
  import timer2_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        t2_count_pin,
  input  wire logic        t2_capture_direction_pin,
  output logic             irq,
  output logic             uart0_rx_baud,
  output logic             uart0_tx_baud,
  output logic             uart1_rx_baud,
  output logic             uart1_tx_baud
);
  ////////////////////////////////////////////////////////////////////////
  logic [7:0]  timer2_control;
  logic [7:0]  timer2_mode_reg;
  logic [15:0] count;
  logic [15:0] reload;
  logic [1:0]  int_mask;
  logic        cnt_level;
  logic        cnt_fall;
  logic        dir_level;
  logic        dir_fall;
  logic [1:0]  pre_cnt;
  logic        prescaled_timer_clock;
  t2_mode_t    mode;
  logic        tick;
  logic        up;
  logic        wrap;
  logic        ext_event;
  logic [15:0] next_count;
  logic        set_ovf;
  logic        wr;
  logic        rd_ack;
  logic [31:0] rd_data;

  pin_sync u_cnt_sync (
    .clock  (clock),
    .arst_n (arst_n),
    .pin    (t2_count_pin),
    .level  (cnt_level),
    .fall   (cnt_fall)
  );
  pin_sync u_dir_sync (
    .clock  (clock),
    .arst_n (arst_n),
    .pin    (t2_capture_direction_pin),
    .level  (dir_level),
    .fall   (dir_fall)
  );

  function automatic logic hit(input logic [11:0] a, input logic [11:0] base);
    hit = (a[11:2] == base[11:2]);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // prescaler: divide by four for the timer clock enable
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pre_cnt <= 2'h0;
    end else begin
      pre_cnt <= pre_cnt + 2'h1;
    end
  end
  assign prescaled_timer_clock = (pre_cnt == 2'(`T2_PRESCALE - 1));

  ////////////////////////////////////////////////////////////////////////
  // mode decode
  always_comb begin
    if (!timer2_control[`T2_CTL_RUN]) begin
      mode = mode_off;
    end else if (timer2_control[`T2_CTL_RX0] | timer2_control[`T2_CTL_TX0] |
                 timer2_mode_reg[`T2_MOD_RX1] | timer2_mode_reg[`T2_MOD_TX1]) begin
      mode = mode_baud;
    end else if (timer2_control[`T2_CTL_CAP]) begin
      mode = mode_capture;
    end else if (timer2_mode_reg[`T2_MOD_DOWN_COUNT_ENABLE]) begin
      mode = mode_updown;
    end else begin
      mode = mode_reload;
    end
  end

  // baud mode always uses the prescaled clock, ignoring counter select
  always_comb begin
    case (mode)
      mode_off:  tick = 1'b0;
      mode_baud: tick = prescaled_timer_clock;
      default:   tick = timer2_control[`T2_CTL_CNT] ? cnt_fall : prescaled_timer_clock;
    endcase
  end

  assign up = (mode != mode_updown) | dir_level;
  assign wrap = tick & (up ? (count == `T2_ALL_ONES) : (count == reload));
  // updown mode uses the pin as direction, so no edge events there
  assign ext_event = timer2_control[`T2_CTL_EXEN] & dir_fall &
                     ((mode == mode_capture) | (mode == mode_reload));

  always_comb begin
    next_count = count;
    if (mode == mode_reload && ext_event) begin
      next_count = reload;
    end else if (tick) begin
      if (wrap) begin
        case (mode)
          mode_capture: next_count = 16'h0000;
          mode_updown:  next_count = up ? reload : `T2_ALL_ONES;
          default:      next_count = reload;
        endcase
      end else begin
        next_count = up ? count + 16'h0001 : count - 16'h0001;
      end
    end
  end

  assign set_ovf = wrap & (mode != mode_baud);

  ////////////////////////////////////////////////////////////////////////
  // baud clock outputs: one pulse per overflow to the selected directions
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      uart0_rx_baud <= 1'b0;
      uart0_tx_baud <= 1'b0;
      uart1_rx_baud <= 1'b0;
      uart1_tx_baud <= 1'b0;
    end else begin
      uart0_rx_baud <= wrap & timer2_control[`T2_CTL_RX0];
      uart0_tx_baud <= wrap & timer2_control[`T2_CTL_TX0];
      uart1_rx_baud <= wrap & timer2_mode_reg[`T2_MOD_RX1];
      uart1_tx_baud <= wrap & timer2_mode_reg[`T2_MOD_TX1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wishbone slave, one wait state; a write lands on the edge that sees ack
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    if (hit(wb_adr_i, `T2_CONTROL_ADDR)) begin
      rd_data = {16'h0000, timer2_mode_reg, timer2_control};
    end else if (hit(wb_adr_i, `T2_COUNT_ADDR)) begin
      rd_data = {16'h0000, count};
    end else if (hit(wb_adr_i, `T2_RELOAD_ADDR)) begin
      rd_data = {16'h0000, reload};
    end else if (hit(wb_adr_i, `T2_STATUS_ADDR)) begin
      rd_data = {30'h00000000, timer2_control[`T2_CTL_EXT], timer2_control[`T2_CTL_OVF]};
    end else if (hit(wb_adr_i, `T2_MASK_ADDR)) begin
      rd_data = {30'h00000000, int_mask};
    end
  end
  assign rd_ack = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd_ack) begin
      wb_dat_o <= rd_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control register; flags: software write, hardware set wins
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      timer2_control <= `T2_RESET_BYTE;
    end else begin
      if (wr && wb_sel_i[0] && hit(wb_adr_i, `T2_CONTROL_ADDR)) begin
        timer2_control <= wb_dat_i[7:0];
      end else if (wr && wb_sel_i[0] && hit(wb_adr_i, `T2_STATUS_ADDR)) begin
        if (wb_dat_i[0]) begin
          timer2_control[`T2_CTL_OVF] <= 1'b0;
        end
        if (wb_dat_i[1]) begin
          timer2_control[`T2_CTL_EXT] <= 1'b0;
        end
      end
      if (set_ovf) begin
        timer2_control[`T2_CTL_OVF] <= 1'b1;
      end
      if (ext_event) begin
        timer2_control[`T2_CTL_EXT] <= 1'b1;
      end else if (mode == mode_updown && wrap) begin
        timer2_control[`T2_CTL_EXT] <= ~timer2_control[`T2_CTL_EXT];
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      timer2_mode_reg <= `T2_RESET_BYTE;
      int_mask        <= 2'h0;
    end else if (wr) begin
      // mode byte shares the control word, in byte lane 1
      if (wb_sel_i[1] && hit(wb_adr_i, `T2_MODE_ADDR)) begin
        timer2_mode_reg <= wb_dat_i[15:8] & `T2_MOD_MASK;
      end
      if (wb_sel_i[0] && hit(wb_adr_i, `T2_MASK_ADDR)) begin
        int_mask <= wb_dat_i[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counter and reload/capture; software write beats count update, capture beats reload write
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      count <= 16'h0000;
    end else if (wr && hit(wb_adr_i, `T2_COUNT_ADDR) && wb_sel_i[1:0] != 2'b00) begin
      count <= {wb_sel_i[1] ? wb_dat_i[15:8] : count[15:8],
                wb_sel_i[0] ? wb_dat_i[7:0] : count[7:0]};
    end else begin
      count <= next_count;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reload <= 16'h0000;
    end else if (mode == mode_capture && ext_event) begin
      reload <= count;
    end else if (wr && hit(wb_adr_i, `T2_RELOAD_ADDR)) begin
      reload <= {wb_sel_i[1] ? wb_dat_i[15:8] : reload[15:8],
                 wb_sel_i[0] ? wb_dat_i[7:0] : reload[7:0]};
    end
  end

  // external flag never interrupts in up/down or baud mode
  always_comb begin
    irq = (timer2_control[`T2_CTL_OVF] & int_mask[0]) |
          (timer2_control[`T2_CTL_EXT] & int_mask[1] &
           (mode != mode_updown) & (mode != mode_baud));
  end

  ////////////////////////////////////////////////////////////////////////
  // counting checks skip write cycles, since a software write may override
  overflow_sets_flag_a: assert property (@(posedge clock) disable iff (!arst_n)
    set_ovf |=> timer2_control[`T2_CTL_OVF])
    else $error("overflow flag not set");
  ovf_irq_a: assert property (@(posedge clock) disable iff (!arst_n)
    (timer2_control[`T2_CTL_OVF] && int_mask[0]) |-> irq)
    else $error("overflow interrupt missing");
  pin_select_a: assert property (@(posedge clock) disable iff (!arst_n)
    (mode != mode_off && mode != mode_baud && timer2_control[`T2_CTL_CNT] && !cnt_fall &&
     !ext_event && !wr) |=> $stable(count))
    else $error("count moved without a pin edge");
  pin_counts_a: assert property (@(posedge clock) disable iff (!arst_n)
    (mode == mode_reload && timer2_control[`T2_CTL_CNT] && cnt_fall && !wrap &&
     !ext_event && !wr) |=> count == $past(count) + 16'h0001)
    else $error("pin edge not counted");
  stopped_holds_count_a: assert property (@(posedge clock) disable iff (!arst_n)
    (mode == mode_off && !wr) |=> $stable(count))
    else $error("count moved while stopped");
  capture_wraps_zero_a: assert property (@(posedge clock) disable iff (!arst_n)
    (mode == mode_capture && wrap && !wr) |=>
      (count == 16'h0000) && timer2_control[`T2_CTL_OVF])
    else $error("capture mode overflow wrong");
  capture_copies_count_a: assert property (@(posedge clock) disable iff (!arst_n)
    (mode == mode_capture && ext_event) |=>
      (reload == $past(count)) && timer2_control[`T2_CTL_EXT])
    else $error("capture missed");
  capture_keeps_count_a: assert property (@(posedge clock) disable iff (!arst_n)
    (mode == mode_capture && ext_event && !tick && !wr) |=> $stable(count))
    else $error("capture disturbed count");
  capture_ext_irq_a: assert property (@(posedge clock) disable iff (!arst_n)
    (mode == mode_capture && timer2_control[`T2_CTL_EXT] && int_mask[1]) |-> irq)
    else $error("capture interrupt missing");
  irq_masked_a: assert property (@(posedge clock) disable iff (!arst_n)
    (int_mask == 2'h0) |-> !irq)
    else $error("interrupt while masked");
  reload_on_wrap_a: assert property (@(posedge clock) disable iff (!arst_n)
    (mode == mode_reload && wrap && !wr) |=> count == $past(reload))
    else $error("no reload on overflow");
  ext_edge_reload_a: assert property (@(posedge clock) disable iff (!arst_n)
    (mode == mode_reload && ext_event && !wr) |=>
      (count == $past(reload)) && timer2_control[`T2_CTL_EXT])
    else $error("pin edge did not reload");
  no_exen_edge_a: assert property (@(posedge clock) disable iff (!arst_n)
    (dir_fall && !timer2_control[`T2_CTL_EXEN] && mode == mode_capture && !wr) |=>
      $stable(reload))
    else $error("edge acted without enable");
  up_counts_a: assert property (@(posedge clock) disable iff (!arst_n)
    (mode == mode_reload && tick && !wrap && !ext_event && !wr) |=>
      count == $past(count) + 16'h0001)
    else $error("up count wrong");
  down_counts_a: assert property (@(posedge clock) disable iff (!arst_n)
    (mode == mode_updown && tick && !up && !wrap && !wr) |=>
      count == $past(count) - 16'h0001)
    else $error("down count wrong");
  updown_up_wrap_a: assert property (@(posedge clock) disable iff (!arst_n)
    (mode == mode_updown && wrap && up && !wr) |=> count == $past(reload))
    else $error("up wrap did not reload");
  down_wrap_ones_a: assert property (@(posedge clock) disable iff (!arst_n)
    (mode == mode_updown && wrap && !up && !wr) |=> count == `T2_ALL_ONES)
    else $error("underflow did not load ones");
  down_wrap_flag_a: assert property (@(posedge clock) disable iff (!arst_n)
    (mode == mode_updown && wrap && !up) |=> timer2_control[`T2_CTL_OVF])
    else $error("underflow did not set flag");
  updown_toggles_ext_a: assert property (@(posedge clock) disable iff (!arst_n)
    (mode == mode_updown && wrap && !wr) |=>
      timer2_control[`T2_CTL_EXT] != $past(timer2_control[`T2_CTL_EXT]))
    else $error("external flag did not toggle");
  updown_no_ext_irq_a: assert property (@(posedge clock) disable iff (!arst_n)
    (mode == mode_updown && !int_mask[0]) |-> !irq)
    else $error("external flag interrupted in up/down");
  baud_pulse_a: assert property (@(posedge clock) disable iff (!arst_n)
    (wrap && timer2_control[`T2_CTL_TX0]) |=> uart0_tx_baud)
    else $error("baud pulse missing");
  rx0_pulse_a: assert property (@(posedge clock) disable iff (!arst_n)
    (wrap && timer2_control[`T2_CTL_RX0]) |=> uart0_rx_baud)
    else $error("receive baud pulse missing");
  rx1_pulse_a: assert property (@(posedge clock) disable iff (!arst_n)
    (wrap && timer2_mode_reg[`T2_MOD_RX1]) |=> uart1_rx_baud)
    else $error("second receive baud pulse missing");
  tx1_pulse_a: assert property (@(posedge clock) disable iff (!arst_n)
    (wrap && timer2_mode_reg[`T2_MOD_TX1]) |=> uart1_tx_baud)
    else $error("second transmit baud pulse missing");
  baud_tick_a: assert property (@(posedge clock) disable iff (!arst_n)
    (mode == mode_baud && !prescaled_timer_clock && !wr) |=> $stable(count))
    else $error("baud count off the timer clock");
  baud_priority_a: assert property (@(posedge clock) disable iff (!arst_n)
    (timer2_control[`T2_CTL_RUN] && (timer2_control[`T2_CTL_RX0] ||
     timer2_control[`T2_CTL_TX0] || timer2_mode_reg[`T2_MOD_RX1] ||
     timer2_mode_reg[`T2_MOD_TX1])) |-> mode == mode_baud)
    else $error("baud select lost priority");
  stop_priority_a: assert property (@(posedge clock) disable iff (!arst_n)
    !timer2_control[`T2_CTL_RUN] |-> mode == mode_off)
    else $error("run bit lost priority");
  baud_no_flag_a: assert property (@(posedge clock) disable iff (!arst_n)
    (mode == mode_baud && !timer2_control[`T2_CTL_OVF] && !wr) |=>
      !timer2_control[`T2_CTL_OVF])
    else $error("baud roll-over set flag");
  set_beats_clear_a: assert property (@(posedge clock) disable iff (!arst_n)
    (set_ovf && wr) |=> timer2_control[`T2_CTL_OVF])
    else $error("clear beat set");
  ext_set_wins_a: assert property (@(posedge clock) disable iff (!arst_n)
    (ext_event && wr) |=> timer2_control[`T2_CTL_EXT])
    else $error("clear beat external set");
  count_pin_fall_a: assert property (@(posedge clock) disable iff (!arst_n)
    cnt_fall |=> !cnt_level)
    else $error("count pin edge without low level");
  capture_pin_fall_a: assert property (@(posedge clock) disable iff (!arst_n)
    dir_fall |=> !dir_level)
    else $error("capture pin edge without low level");
  ack_pulse_a: assert property (@(posedge clock) disable iff (!arst_n)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  ack_answer_a: assert property (@(posedge clock) disable iff (!arst_n)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("ack missing");
endmodule
`default_nettype wire

// ===== rtl/timer2_regs.svh
// How it works
// - outside baud mode, counter overflow or underflow sets the overflow flag, which may interrupt
// - counter select picks internal clock or falling edges on count pin; 16 bits
// - capture mode without external enable is a plain 16-bit timer/counter
// - capture mode with external enable: pin falling edge copies count, sets flag
// - in capture mode the external flag requests interrupt like overflow flag
// - auto-reload mode reloads count from reload bytes on every overflow
// - up-only reload with external enable: pin falling edge reloads, sets flag
// - down-count enable clear counts up only, overflow past ffff reloads
// - down-count enable set: pin high counts up, pin low counts down
// - counting down, count equal reload value loads all ones, sets overflow
// - up/down mode toggles external flag on each wrap; no interrupt from it
// - each port direction clock select routes the overflow rate as baud clock
// - baud mode increments on the prescaled timer clock
// - priority: stopped, baud, capture, then auto-reload up or up/down
// - baud mode roll-overs never set the interrupt request
`ifndef TIMER2_REGS_SVH
`define TIMER2_REGS_SVH
`define T2_CONTROL_ADDR  12'h418
`define T2_MODE_ADDR     12'h419
`define T2_COUNT_ADDR    12'h420
`define T2_RELOAD_ADDR   12'h424
`define T2_STATUS_ADDR   12'h428
`define T2_MASK_ADDR     12'h42c
`define T2_CTL_OVF       7
`define T2_CTL_EXT       6
`define T2_CTL_RX0       5
`define T2_CTL_TX0       4
`define T2_CTL_EXEN      3
`define T2_CTL_RUN       2
`define T2_CTL_CNT       1
`define T2_CTL_CAP       0
`define T2_MOD_RX1       5
`define T2_MOD_TX1       4
`define T2_MOD_DOWN_COUNT_ENABLE      0
`define T2_MOD_MASK      8'h31
`define T2_RESET_BYTE    8'h00
`define T2_ALL_ONES      16'hffff
`define T2_PRESCALE      4
`endif

// ===== rtl/timer2_pkg.sv
`default_nettype none
package timer2_pkg;
  typedef enum logic [2:0] {
    mode_off     = 3'b000,
    mode_reload  = 3'b001,
    mode_updown  = 3'b011,
    mode_capture = 3'b010,
    mode_baud    = 3'b110
  } t2_mode_t;
endpackage
`default_nettype wire

// ===== rtl/pin_sync.sv
`default_nettype none
module pin_sync (
  input  wire logic clock,
  input  wire logic arst_n,
  input  wire logic pin,
  output logic      level,
  output logic      fall
);
  logic stage1;
  logic stage2;
  // stage1 only feeds stage2; edge compares later samples
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= 1'b1;
      stage2 <= 1'b1;
      level  <= 1'b1;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      level  <= stage2;
    end
  end
  assign fall = level & ~stage2;
endmodule
`default_nettype wire

// ===== dv/t2_pins_model.sv
`default_nettype none
module t2_pins_model (
  input  wire logic clock,
  output logic      count_pin,
  output logic      capture_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // both pins idle high; no edges unless a scenario asks for them
  initial begin
    count_pin   = 1'b1;
    capture_pin = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  // four low and four high clocks, longer than the pin synchroniser delay
  task automatic pulse_count(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      count_pin <= 1'b0;
      repeat (4) @(posedge clock);
      count_pin <= 1'b1;
      repeat (4) @(posedge clock);
    end
  endtask
  // level change given time to pass the synchroniser
  task automatic set_direction(input logic up);
    @(posedge clock);
    capture_pin <= up;
    repeat (4) @(posedge clock);
  endtask
  task automatic pulse_capture();
    @(posedge clock);
    capture_pin <= 1'b0;
    repeat (4) @(posedge clock);
    capture_pin <= 1'b1;
    repeat (4) @(posedge clock);
  endtask
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
`default_nettype none
`include "timer2_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic             clock, arst_n, cyc, stb, we;
  logic      [11:0] adr;
  logic      [3:0]  sel;
  logic      [31:0] dat_w, rd;
  wire logic [31:0] dat_r;
  wire logic        ack, irq, rx0, tx0, rx1, tx1, count_pin, cap_pin;
  int               n_errors, num_checks, cycles;

  timer2 i_dut (.clock(clock), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
    .wb_ack_o(ack), .t2_count_pin(count_pin), .t2_capture_direction_pin(cap_pin),
    .irq(irq), .uart0_rx_baud(rx0), .uart0_tx_baud(tx0), .uart1_rx_baud(rx1),
    .uart1_tx_baud(tx1));
  t2_pins_model i_pins (.clock(clock), .count_pin(count_pin), .capture_pin(cap_pin));
  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // request held until ack is sampled high, then released for a cycle
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    check({31'h0, ack}, 32'h1);
    // the write lands on the ack edge; let it settle before callers look
    @(posedge clock);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdchk(`T2_CONTROL_ADDR, 32'h0);
    rdchk(`T2_COUNT_ADDR, 32'h0);
    wr(12'h500, 32'hff);
    rdchk(12'h500, 32'h0);
    check({31'h0, irq}, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_reload();
    wr(`T2_RELOAD_ADDR, 32'h1234);
    wr(`T2_COUNT_ADDR, 32'hfffe);
    wr(`T2_MASK_ADDR, 32'h1);
    wr(`T2_CONTROL_ADDR, 32'h06);
    i_pins.pulse_count(1);
    rdchk(`T2_COUNT_ADDR, 32'hffff);
    i_pins.pulse_count(1);
    rdchk(`T2_COUNT_ADDR, 32'h1234);
    rdchk(`T2_CONTROL_ADDR, 32'h86);
    check({31'h0, irq}, 32'h1);
    wr(`T2_MASK_ADDR, 32'h0);
    check({31'h0, irq}, 32'h0);
    wr(`T2_MASK_ADDR, 32'h1);
    wr(`T2_STATUS_ADDR, 32'h1);
    rdchk(`T2_CONTROL_ADDR, 32'h06);
    check({31'h0, irq}, 32'h0);
    $display("test reload done");
  endtask
  task automatic t_capture();
    wr(`T2_COUNT_ADDR, 32'habcd);
    wr(`T2_MASK_ADDR, 32'h2);
    wr(`T2_CONTROL_ADDR, 32'h0f);
    i_pins.pulse_capture();
    rdchk(`T2_RELOAD_ADDR, 32'habcd);
    rdchk(`T2_CONTROL_ADDR, 32'h4f);
    check({31'h0, irq}, 32'h1);
    wr(`T2_STATUS_ADDR, 32'h2);
    check({31'h0, irq}, 32'h0);
    // no exen: a pin edge must leave the captured bytes alone
    wr(`T2_RELOAD_ADDR, 32'h2222);
    wr(`T2_COUNT_ADDR, 32'hffff);
    wr(`T2_CONTROL_ADDR, 32'h07);
    i_pins.pulse_count(1);
    i_pins.pulse_capture();
    rdchk(`T2_COUNT_ADDR, 32'h0);
    rdchk(`T2_RELOAD_ADDR, 32'h2222);
    rdchk(`T2_CONTROL_ADDR, 32'h87);
    $display("test capture done");
  endtask
  task automatic t_ext_reload();
    wr(`T2_RELOAD_ADDR, 32'h5555);
    wr(`T2_COUNT_ADDR, 32'h0100);
    wr(`T2_CONTROL_ADDR, 32'h0e);
    i_pins.pulse_capture();
    rdchk(`T2_COUNT_ADDR, 32'h5555);
    rdchk(`T2_CONTROL_ADDR, 32'h4e);
    wr(`T2_CONTROL_ADDR, 32'h02);
    i_pins.pulse_count(2);
    rdchk(`T2_COUNT_ADDR, 32'h5555);
    $display("test ext reload done");
  endtask
  task automatic t_baud();
    int n;
    int m;
    n = 0;
    m = 0;
    wr(`T2_RELOAD_ADDR, 32'hfff0);
    wr(`T2_COUNT_ADDR, 32'hfff0);
    wr(`T2_MASK_ADDR, 32'h1);
    wr(`T2_CONTROL_ADDR, 32'h15);
    while (tx0 !== 1'b1 && n < 300) begin
      @(posedge clock);
      n++;
    end
    n = 0;
    do begin
      @(posedge clock);
      n++;
      m += int'(rx0 === 1'b1);
    end while (tx0 !== 1'b1 && n < 300);
    check(n, 32'd64);
    check(m, 32'd0);
    rdchk(`T2_CONTROL_ADDR, 32'h15);
    check({31'h0, irq}, 32'h0);
    wr(`T2_CONTROL_ADDR, 32'h00);
    $display("test baud done");
  endtask
  task automatic t_updown();
    int n;
    n = 0;
    wr(`T2_RELOAD_ADDR, 32'h0005);
    wr(`T2_COUNT_ADDR, 32'h0006);
    wr(`T2_MASK_ADDR, 32'h1);
    wr(`T2_CONTROL_ADDR, 32'h0106);
    rdchk(`T2_CONTROL_ADDR, 32'h0106);
    i_pins.set_direction(1'b0);
    i_pins.pulse_count(1);
    rdchk(`T2_COUNT_ADDR, 32'h0005);
    i_pins.pulse_count(1);
    rdchk(`T2_COUNT_ADDR, 32'hffff);
    rdchk(`T2_CONTROL_ADDR, 32'h01c6);
    check({31'h0, irq}, 32'h1);
    wr(`T2_MASK_ADDR, 32'h2);
    check({31'h0, irq}, 32'h0);
    i_pins.set_direction(1'b1);
    i_pins.pulse_count(1);
    rdchk(`T2_COUNT_ADDR, 32'h0005);
    rdchk(`T2_CONTROL_ADDR, 32'h0186);
    wr(`T2_COUNT_ADDR, 32'hfff0);
    wr(`T2_CONTROL_ADDR, 32'h2004);
    while (rx1 !== 1'b1 && n < 300) begin
      @(posedge clock);
      n++;
    end
    check({31'h0, rx1}, 32'h1);
    check({31'h0, tx1}, 32'h0);
    rdchk(`T2_CONTROL_ADDR, 32'h2004);
    wr(`T2_CONTROL_ADDR, 32'h00);
    $display("test updown done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // ceiling well above the several hundred cycles the tests need
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      results();
    end
  end
  initial begin
    n_errors = 0;
    num_checks = 0;
    cycles = 0;
    arst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 12'h0;
    sel = 4'h3;
    dat_w = 32'h0;
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    t_reset();
    t_reload();
    t_capture();
    t_ext_reload();
    t_baud();
    t_updown();
    results();
  end
endmodule
`default_nettype wire
